// >>> logic/pgsr_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
// What this block does
// RULE1: Low-channel register at index 4, resets zero.
// RULE2: High-channel register at index 5, resets zero.
// RULE3: Channel 0 code is low bits 2:0.
// RULE4: Channel 1 code is low bits 6:4.
// RULE5: Channel 2 code is low bits 10:8.
// RULE6: Channel 3 code is low bits 14:12.
// RULE7: Channel 4 code is high bits 2:0.
// RULE8: Channel 5 code is high bits 6:4.
// RULE9: Channel 6 code is high bits 10:8.
// RULE10: Channel 7 code is high bits 14:12.
// RULE11: Reads return codes, reserved zero; writes apply.
module pgsr_top
    import pgsr_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [PGSR_ADDR_W-1:0]  paddr,
    input  wire logic [PGSR_DATA_W-1:0]  pwdata,
    output logic      [PGSR_DATA_W-1:0]  prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch0,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch1,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch2,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch3,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch4,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch5,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch6,
    output logic      [PGSR_CODE_W-1:0]  amp_code_ch7,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch0,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch1,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch2,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch3,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch4,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch5,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch6,
    output logic      [PGSR_GAIN_W-1:0]  gain_sel_ch7
);

    // Address decode used by both the read path and the write path.
    function automatic logic [1:0] pgsr_addr_hit(input logic [PGSR_ADDR_W-1:0] addr);
        logic [1:0] hit;
        hit[0] = (addr == PGSR_ADDR_GAIN_LOW);
        hit[1] = (addr == PGSR_ADDR_GAIN_HIGH);
        return hit;
    endfunction : pgsr_addr_hit

    // Bus slave state.
    pgsr_phase_e             phase_r;
    pgsr_phase_e             phase_nxt;
    logic                    pready_r;
    logic                    pready_nxt;
    logic                    pslverr_r;
    logic                    pslverr_nxt;
    logic [PGSR_DATA_W-1:0]  prdata_r;
    logic [PGSR_DATA_W-1:0]  prdata_nxt;

    // Gain registers; only field bits ever hold state.
    logic [PGSR_REG_W-1:0]   gain_low_r;
    logic [PGSR_REG_W-1:0]   gain_low_nxt;
    logic [PGSR_REG_W-1:0]   gain_high_r;
    logic [PGSR_REG_W-1:0]   gain_high_nxt;

    // Decoded bus conditions.
    logic                    setup_phase;
    logic                    access_done;
    logic [1:0]              setup_hit;
    logic [1:0]              access_hit;
    logic                    setup_mapped;
    logic                    wr_low;
    logic                    wr_high;
    logic [PGSR_REG_W-1:0]   wdata_masked;
    logic [PGSR_REG_W-1:0]   rd_word;

    // Carrier between the bank and the decoder.
    pgsr_gain_if             gif ();

    // A setup cycle is psel without penable; the access completes on the
    // edge where our own pready is already high, so the answer is zero-wait.
    assign setup_phase  = psel && !penable;
    assign access_done  = psel && penable && pready_r;
    assign setup_hit    = pgsr_addr_hit(paddr);
    assign access_hit   = pgsr_addr_hit(paddr);
    assign setup_mapped = |setup_hit;

    // RULE11 reserved dropped
    // Reserved bits are never stored, so they read back as zero whatever
    // the host writes; the upper half of the bus word is ignored.
    assign wdata_masked = pwdata[PGSR_REG_W-1:0] & PGSR_FIELD_MASK;

    // RULE1 low decode
    assign wr_low  = access_done && pwrite && access_hit[0];
    // RULE2 high decode
    assign wr_high = access_done && pwrite && access_hit[1];

    // RULE11 write applies
    assign gain_low_nxt  = wr_low  ? wdata_masked : gain_low_r;
    assign gain_high_nxt = wr_high ? wdata_masked : gain_high_r;

    // RULE11 read mux
    // Read data is captured in the setup cycle; no write can land between
    // setup and completion of the same transfer, so the value is current.
    assign rd_word = setup_hit[0] ? (gain_low_r  & PGSR_FIELD_MASK) :
                     setup_hit[1] ? (gain_high_r & PGSR_FIELD_MASK) :
                                    PGSR_RST_GAIN;

    // Next-state logic of the bus slave.
    always_comb
    begin
        phase_nxt   = phase_r;
        pready_nxt  = pready_r;
        pslverr_nxt = pslverr_r;
        prdata_nxt  = prdata_r;
        case (phase_r)
            PGSR_IDLE:
            begin
                if (setup_phase)
                begin
                    phase_nxt   = PGSR_ACCESS;
                    pready_nxt  = 1'b1;
                    // Unmapped addresses answer with an error and zero data.
                    pslverr_nxt = !setup_mapped;
                    prdata_nxt  = pwrite ? '0 : {{(PGSR_DATA_W-PGSR_REG_W){1'b0}}, rd_word};
                end
            end
            PGSR_ACCESS:
            begin
                // Ready and error fall once the transfer has completed,
                // or if the master abandoned the transfer.
                if (access_done || !psel)
                begin
                    phase_nxt   = PGSR_IDLE;
                    pready_nxt  = 1'b0;
                    pslverr_nxt = 1'b0;
                end
            end
            default:
            begin
                phase_nxt   = PGSR_IDLE;
                pready_nxt  = 1'b0;
                pslverr_nxt = 1'b0;
            end
        endcase
    end

    // Bus slave flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r   <= PGSR_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end
        else
        begin
            phase_r   <= phase_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // RULE1 low reset
    // RULE2 high reset
    // Both gain registers return to gain 1 on every channel at reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_low_r  <= PGSR_RST_GAIN;
            gain_high_r <= PGSR_RST_GAIN;
        end
        else
        begin
            gain_low_r  <= gain_low_nxt;
            gain_high_r <= gain_high_nxt;
        end
    end

    // Field extraction: channel k of a register sits at bit 4*k, three bits
    // wide, with the reserved bit above it.
    genvar k;
    generate
        for (k = 0; k < PGSR_CH_PER_REG; k++)
        begin : g_field
            // RULE3 RULE4 RULE5 RULE6 low fields
            assign gif.code[k] = gain_low_r[k*PGSR_FIELD_PITCH +: PGSR_CODE_W];
            // RULE7 RULE8 RULE9 RULE10 high fields
            assign gif.code[k+PGSR_CH_PER_REG] = gain_high_r[k*PGSR_FIELD_PITCH +: PGSR_CODE_W];
        end
    endgenerate

    // RULE3 shared decode
    // One decoder serves all eight channels, so the power-of-two mapping
    // cannot drift between channels.
    pgsr_decode u_decode
    (
        .pclk    (pclk),
        .presetn (presetn),
        .gif     (gif)
    );

    // Bus outputs come straight from their flops.
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // Code outputs are register bits; they change on the write edge.
    assign amp_code_ch0 = gif.code[0];
    assign amp_code_ch1 = gif.code[1];
    assign amp_code_ch2 = gif.code[2];
    assign amp_code_ch3 = gif.code[3];
    assign amp_code_ch4 = gif.code[4];
    assign amp_code_ch5 = gif.code[5];
    assign amp_code_ch6 = gif.code[6];
    assign amp_code_ch7 = gif.code[7];

    // Select outputs come from the decoder flops, one edge after the code.
    assign gain_sel_ch0 = gif.sel[0];
    assign gain_sel_ch1 = gif.sel[1];
    assign gain_sel_ch2 = gif.sel[2];
    assign gain_sel_ch3 = gif.sel[3];
    assign gain_sel_ch4 = gif.sel[4];
    assign gain_sel_ch5 = gif.sel[5];
    assign gain_sel_ch6 = gif.sel[6];
    assign gain_sel_ch7 = gif.sel[7];

endmodule : pgsr_top

// >>> logic/pgsr_pkg.sv
// Shared constants for the amplifier gain select register bank.
package pgsr_pkg;

    // Bus widths.
    localparam int unsigned PGSR_ADDR_W    = 12;
    localparam int unsigned PGSR_DATA_W    = 32;
    localparam int unsigned PGSR_REG_W     = 16;

    // Channel and field geometry.
    localparam int unsigned PGSR_NUM_CH    = 8;
    localparam int unsigned PGSR_CH_PER_REG = 4;
    localparam int unsigned PGSR_CODE_W    = 3;
    localparam int unsigned PGSR_FIELD_PITCH = 4;
    localparam int unsigned PGSR_GAIN_W    = 8;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [PGSR_ADDR_W-1:0] PGSR_IDX_GAIN_LOW  = 12'h004;
    localparam logic [PGSR_ADDR_W-1:0] PGSR_IDX_GAIN_HIGH = 12'h005;
    localparam logic [PGSR_ADDR_W-1:0] PGSR_ADDR_GAIN_LOW  = PGSR_ADDR_W'(PGSR_IDX_GAIN_LOW * 4);
    localparam logic [PGSR_ADDR_W-1:0] PGSR_ADDR_GAIN_HIGH = PGSR_ADDR_W'(PGSR_IDX_GAIN_HIGH * 4);

    // Reset values and the mask of bits that hold state (reserved bits excluded).
    localparam logic [PGSR_REG_W-1:0] PGSR_RST_GAIN = 16'h0000;
    localparam logic [PGSR_REG_W-1:0] PGSR_FIELD_MASK = 16'h7777;
    localparam logic [PGSR_CODE_W-1:0] PGSR_CODE_RST = 3'h0;
    localparam logic [PGSR_GAIN_W-1:0] PGSR_GAIN_RST = 8'h01;

    // Phases of the bus slave.
    typedef enum logic
    {
        PGSR_IDLE,
        PGSR_ACCESS
    } pgsr_phase_e;

endpackage : pgsr_pkg

// >>> logic/pgsr_gain_if.sv
`timescale 1ns/1ps
// Carries the stored gain codes to the decoder and the decoded selects back.
interface pgsr_gain_if;
    import pgsr_pkg::*;

    logic [PGSR_CODE_W-1:0] code [PGSR_NUM_CH];
    logic [PGSR_GAIN_W-1:0] sel  [PGSR_NUM_CH];

    // The register bank drives codes and reads selects.
    modport src (output code, input sel);
    // The decoder reads codes and drives selects.
    modport dec (input code, output sel);

endinterface : pgsr_gain_if

// >>> logic/pgsr_decode.sv
`timescale 1ns/1ps
// Turns each channel's gain code into a registered one-hot amplifier select.
module pgsr_decode
    import pgsr_pkg::*;
(
    input wire logic   pclk,
    input wire logic   presetn,
    pgsr_gain_if.dec   gif
);

    // Code n selects gain two to the power n, so bit n of the select is set.
    function automatic logic [PGSR_GAIN_W-1:0] pgsr_code_to_sel(input logic [PGSR_CODE_W-1:0] code);
        logic [PGSR_GAIN_W-1:0] sel;
        sel = PGSR_GAIN_RST << code;
        return sel;
    endfunction : pgsr_code_to_sel

    genvar ch;
    generate
        for (ch = 0; ch < PGSR_NUM_CH; ch++)
        begin : g_ch
            logic [PGSR_GAIN_W-1:0] sel_nxt;
            logic [PGSR_GAIN_W-1:0] sel_r;

            assign sel_nxt = pgsr_code_to_sel(gif.code[ch]);

            // Registered so the analogue stage never sees a decode glitch.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sel_r <= PGSR_GAIN_RST;
                else
                    sel_r <= sel_nxt;
            end

            assign gif.sel[ch] = sel_r;
        end
    endgenerate

endmodule : pgsr_decode

// >>> testbench/pgsr_props.sv
`timescale 1ns/1ps
// Watches the bus answer and the outer channels of the gain bank at the top ports.
module pgsr_props
    import pgsr_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [PGSR_ADDR_W-1:0] paddr,
    input wire logic [PGSR_DATA_W-1:0] pwdata,
    input wire logic [PGSR_DATA_W-1:0] prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [PGSR_CODE_W-1:0] amp_code_ch0,
    input wire logic [PGSR_CODE_W-1:0] amp_code_ch7,
    input wire logic [PGSR_GAIN_W-1:0] gain_sel_ch0,
    input wire logic [PGSR_GAIN_W-1:0] gain_sel_ch7
);
    // Bus phases; a refused write must leave the codes alone, so it is kept out of wr_done.
    wire setup   = psel && !penable;
    wire mapped  = (paddr == PGSR_ADDR_GAIN_LOW) || (paddr == PGSR_ADDR_GAIN_HIGH);
    wire wr_done = psel && penable && pready && pwrite && !pslverr;
    wire rd_low  = setup && !pwrite && (paddr == PGSR_ADDR_GAIN_LOW);
    wire rd_high = setup && !pwrite && (paddr == PGSR_ADDR_GAIN_HIGH);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_next: assert property (setup |=> pready)
        else $error("pready did not follow a setup cycle.");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle.");
    a_err_map: assert property (setup |=> pslverr == !$past(mapped))
        else $error("pslverr does not match the address map.");
    a_low_store: assert property (wr_done && paddr == PGSR_ADDR_GAIN_LOW |=> amp_code_ch0 == $past(pwdata[2:0]))
        else $error("Channel 0 code not taken from bits 2:0.");
    a_high_store: assert property (wr_done && paddr == PGSR_ADDR_GAIN_HIGH |=> amp_code_ch7 == $past(pwdata[14:12]))
        else $error("Channel 7 code not taken from bits 14:12.");
    a_sel_ch0: assert property (gain_sel_ch0 == (8'h01 << $past(amp_code_ch0)))
        else $error("Channel 0 select is not the decoded code.");
    a_sel_ch7: assert property (gain_sel_ch7 == (8'h01 << $past(amp_code_ch7)))
        else $error("Channel 7 select is not the decoded code.");
    a_read_low: assert property (rd_low |=> prdata[31:16] == 16'h0000 && prdata[3:0] == {1'b0, amp_code_ch0})
        else $error("Low register readback is wrong.");
    a_read_high: assert property (rd_high |=> prdata[31:12] == {16'h0000, 1'b0, amp_code_ch7})
        else $error("High register readback is wrong.");
    a_refused_hold: assert property (psel && penable && pready && pwrite && pslverr |=> $stable(amp_code_ch0))
        else $error("A refused write changed a code.");

    // Main traffic kinds seen at least once.
    c_write: cover property (wr_done);
    c_read: cover property (rd_high);
    c_refused: cover property (pready && pslverr);
endmodule : pgsr_props

bind pgsr_top pgsr_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .amp_code_ch0, .amp_code_ch7, .gain_sel_ch0, .gain_sel_ch7);

// >>> testbench/pgsr_top_tb.sv
`timescale 1ns/1ps
// Drives the gain bank over its register bus and checks readback, codes and decoded selects.
module pgsr_top_tb import pgsr_pkg::*;;
    logic                   pclk     = 1'b0;
    logic                   presetn  = 1'b0;
    logic                   psel     = 1'b0;
    logic                   penable  = 1'b0;
    logic                   pwrite   = 1'b0;
    logic [PGSR_ADDR_W-1:0] paddr    = '0;
    logic [PGSR_DATA_W-1:0] pwdata   = '0;
    logic [PGSR_DATA_W-1:0] prdata;
    logic                   pready;
    logic                   pslverr;
    logic [PGSR_CODE_W-1:0] code [PGSR_NUM_CH];
    logic [PGSR_GAIN_W-1:0] sel  [PGSR_NUM_CH];
    logic [PGSR_CODE_W-1:0] ec   [PGSR_NUM_CH];
    logic [PGSR_DATA_W-1:0] rd;
    logic                   err;
    int                     fails    = 0;
    int                     n_checks = 0;
    int                     cycles   = 0;

    pgsr_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .amp_code_ch0(code[0]), .amp_code_ch1(code[1]), .amp_code_ch2(code[2]), .amp_code_ch3(code[3]),
        .amp_code_ch4(code[4]), .amp_code_ch5(code[5]), .amp_code_ch6(code[6]), .amp_code_ch7(code[7]),
        .gain_sel_ch0(sel[0]), .gain_sel_ch1(sel[1]), .gain_sel_ch2(sel[2]), .gain_sel_ch3(sel[3]),
        .gain_sel_ch4(sel[4]), .gain_sel_ch5(sel[5]), .gain_sel_ch6(sel[6]), .gain_sel_ch7(sel[7]));

    // Bus clock at 20 MHz.
    always #25 pclk = ~pclk;

    // Cuts a hang short; the full run needs under 150 cycles.
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            test_done();
        end
    end

    // Compares one observed value with its expected value.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One transfer; the request is held until pready is sampled high, then the bus idles a cycle.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        chk("access cycles", 32'(n), 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    // Optionally writes the codes in ec, then checks both readbacks and every code and select.
    task automatic check_all(input logic do_wr);
        logic [PGSR_DATA_W-1:0] lo;
        logic [PGSR_DATA_W-1:0] hi;
        lo = '0;
        hi = '0;
        for (int c = 0; c < 4; c++)
        begin
            lo[4*c +: 3] = ec[c];
            hi[4*c +: 3] = ec[c+4];
        end
        if (do_wr)
        begin
            // Junk in the upper half must be ignored by the bank.
            xfer(1'b1, PGSR_ADDR_GAIN_LOW, lo | 32'hA5A5_0000);
            xfer(1'b1, PGSR_ADDR_GAIN_HIGH, hi | 32'h5A5A_0000);
        end
        xfer(1'b0, PGSR_ADDR_GAIN_LOW, '0);
        chk("low readback", rd, lo);
        xfer(1'b0, PGSR_ADDR_GAIN_HIGH, '0);
        chk("high readback", rd, hi);
        for (int c = 0; c < 8; c++)
        begin
            chk("amp_code", 32'(code[c]), 32'(ec[c]));
            chk("gain_sel", 32'(sel[c]), 32'h1 << ec[c]);
        end
    endtask : check_all

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Reset values, every code on every channel, refused accesses, then a reset in mid-run.
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ec = '{default: 3'h0};
        check_all(1'b0);
        $display("Test reset values done");
        for (int k = 0; k < 8; k++)
        begin
            for (int c = 0; c < 8; c++)
                ec[c] = 3'(k + c);
            check_all(1'b1);
        end
        $display("Test all codes done");
        xfer(1'b1, 12'h018, 32'h0000_7777);
        chk("write refused", 32'(err), 32'h1);
        xfer(1'b0, 12'h00C, '0);
        chk("read refused", 32'(err), 32'h1);
        chk("refused data", rd, 32'h0);
        check_all(1'b0);
        $display("Test unmapped access done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ec = '{default: 3'h0};
        check_all(1'b0);
        $display("Test mid-run reset done");
        test_done();
    end
endmodule : pgsr_top_tb
